/* flash_cpu_port.sv */
// CPU-side access controller: AHB-Lite registers drive flash link requests
`timescale 1ns/1ps
module flash_cpu_port (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic irq_req,
    output logic irq_out,
    flash_link_if.cpu link
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_ISSUE = 2'b01,
        H_WAIT = 2'b10
    } hstate_t;

    hstate_t hst_q;
    flash_iap_pkg::op_t op_q;
    logic [13:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic denied_q;
    logic refused_q;
    logic pend_q;
    logic irq_q;
    logic [31:0] hrdata_q;
    logic wr_pend_q;
    logic [7:0] wr_off_q;
    logic rd_sel;
    logic wr_cmd;
    logic [3:0] status;

    assign rd_sel = hsel && htrans[1] && hready && !hwrite;
    assign wr_cmd = wr_pend_q && wr_off_q == flash_iap_pkg::HOST_CMD_OFF;
    assign status = {pend_q, refused_q, denied_q, (hst_q != H_IDLE) || link.busy};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_off_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= hsel && htrans[1] && hready && hwrite;
            wr_off_q <= haddr[7:0];
            if (rd_sel) begin
                unique case (haddr[7:0])
                    flash_iap_pkg::HOST_CMD_OFF: hrdata_q <= {29'h0000_0000, op_q};
                    flash_iap_pkg::HOST_ADDR_OFF: hrdata_q <= {18'h0_0000, addr_q};
                    flash_iap_pkg::HOST_WDATA_OFF: hrdata_q <= {24'h00_0000, wdata_q};
                    flash_iap_pkg::HOST_STATUS_OFF: hrdata_q <= {28'h000_0000, status};
                    flash_iap_pkg::HOST_RDATA_OFF: hrdata_q <= {24'h00_0000, rdata_q};
                    default: hrdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= 14'h0000;
            wdata_q <= 8'h00;
        end else if (wr_pend_q && hst_q == H_IDLE) begin
            if (wr_off_q == flash_iap_pkg::HOST_ADDR_OFF) begin
                addr_q <= hwdata[13:0];
            end
            if (wr_off_q == flash_iap_pkg::HOST_WDATA_OFF) begin
                wdata_q <= hwdata[7:0];
            end
        end
    end

    // Command taken only when idle; data writes refused while supply saving is on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hst_q <= H_IDLE;
            op_q <= flash_iap_pkg::OP_NONE;
            rdata_q <= 8'h00;
        end else begin
            unique case (hst_q)
                H_IDLE: begin
                    if (wr_cmd && !link.busy && hwdata[2:0] != 3'b000
                        && !(hwdata[2:0] == 3'b001 && link.core_supply_saving)) begin
                        op_q <= flash_iap_pkg::op_t'(hwdata[2:0]);
                        hst_q <= H_ISSUE;
                    end
                end
                H_ISSUE: begin
                    hst_q <= H_WAIT;
                end
                H_WAIT: begin
                    if (link.done) begin
                        rdata_q <= link.rdata;
                        hst_q <= H_IDLE;
                    end
                end
                default: begin
                    hst_q <= H_IDLE;
                end
            endcase
        end
    end

    // Sticky flags: set wins over a write-one clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            denied_q <= 1'b0;
            refused_q <= 1'b0;
            pend_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            if (wr_pend_q && wr_off_q == flash_iap_pkg::HOST_STATUS_OFF) begin
                denied_q <= (denied_q && !hwdata[flash_iap_pkg::ST_DENIED])
                    || (link.done && link.denied);
                refused_q <= (refused_q && !hwdata[flash_iap_pkg::ST_REFUSED])
                    || (wr_cmd && hwdata[2:0] == 3'b001 && link.core_supply_saving);
                pend_q <= (pend_q && !hwdata[flash_iap_pkg::ST_IRQ]) || irq_req;
            end else begin
                denied_q <= denied_q || (link.done && link.denied);
                refused_q <= refused_q || (wr_cmd && hst_q == H_IDLE
                    && hwdata[2:0] == 3'b001 && link.core_supply_saving);
                pend_q <= pend_q || irq_req;
            end
            irq_q <= pend_q && !link.busy && hst_q != H_ISSUE;
        end
    end

    assign link.req = (hst_q == H_ISSUE);
    assign link.op = op_q;
    assign link.addr = addr_q;
    assign link.wdata = wdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign irq_out = irq_q;
endmodule

/* flash_iap_ctrl.sv */
// Flash array controller: permissions, command register, byte write stall, config load
`timescale 1ns/1ps
module flash_iap_ctrl #(
    parameter int unsigned WR_CYCLES = flash_iap_pkg::WR_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    flash_link_if.device link,
    input wire logic six_wire_session,
    output logic hold_pin_o,
    output logic hold_pin_oe,
    output logic core_supply_saving,
    output logic [7:0] cfg_low_sfr
);
    typedef enum logic [1:0] {
        S_LOAD = 2'b00,
        S_IDLE = 2'b01,
        S_WRITE = 2'b10
    } state_t;

    logic [7:0] mem [0:flash_iap_pkg::FLASH_BYTES-1];
    state_t state_q;
    logic [15:0] cnt_q;
    logic [13:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic lock_q;
    logic wide_q;
    logic [7:0] supply_q;
    logic [7:0] cfg_low_q;
    logic busy_q;
    logic done_q;
    logic denied_q;
    logic [7:0] rdata_q;
    logic hold_o_q;
    logic hold_oe_q;
    logic idle_req;
    logic wr_ok;

    // Erased flash content
    initial begin
        for (int i = 0; i < flash_iap_pkg::FLASH_BYTES; i++) begin
            mem[i] = flash_iap_pkg::ERASED_BYTE;
        end
    end

    assign idle_req = link.req && (state_q == S_IDLE);
    assign wr_ok = flash_iap_pkg::data_move_ok(link.addr, lock_q, wide_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= S_LOAD;
            cnt_q <= 16'h0000;
            wr_addr_q <= 14'h0000;
            wr_data_q <= 8'h00;
        end else begin
            unique case (state_q)
                S_LOAD: begin
                    state_q <= S_IDLE;
                end
                S_IDLE: begin
                    if (idle_req && link.op == flash_iap_pkg::OP_DATA_WR && wr_ok) begin
                        state_q <= S_WRITE;
                        cnt_q <= 16'(WR_CYCLES - 1);
                        wr_addr_q <= link.addr;
                        wr_data_q <= link.wdata;
                    end
                end
                S_WRITE: begin
                    if (cnt_q == 16'h0000) begin
                        state_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // Single byte stored in place at the end of the write time
    always_ff @(posedge hclk) begin
        if (state_q == S_WRITE && cnt_q == 16'h0000) begin
            mem[wr_addr_q] <= wr_data_q;
        end
    end

    // Configuration bytes taken in the first cycle after reset release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_q <= 1'b1;
            cfg_low_q <= 8'h00;
        end else if (state_q == S_LOAD) begin
            lock_q <= mem[flash_iap_pkg::CFG_HIGH_ADDR][flash_iap_pkg::LOCK_BIT];
            cfg_low_q <= mem[flash_iap_pkg::CFG_LOW_ADDR];
        end else if (idle_req && link.op == flash_iap_pkg::OP_SFR_WR
                     && link.addr[7:0] == flash_iap_pkg::CFG_LOW_SFR) begin
            cfg_low_q <= link.wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wide_q <= 1'b0;
            supply_q <= flash_iap_pkg::SUPPLY_RESET;
        end else if (idle_req && link.op == flash_iap_pkg::OP_SFR_WR) begin
            if (link.addr[7:0] == flash_iap_pkg::CMD_REG_SFR) begin
                wide_q <= (link.wdata == flash_iap_pkg::WIDE_KEY);
            end
            if (link.addr[7:0] == flash_iap_pkg::SUPPLY_SFR) begin
                supply_q <= link.wdata;
            end
        end
    end

    // Stall held through the load cycle and the whole byte write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_q <= 1'b1;
        end else begin
            busy_q <= (state_q == S_LOAD)
                || (idle_req && link.op == flash_iap_pkg::OP_DATA_WR && wr_ok)
                || (state_q == S_WRITE && cnt_q != 16'h0000);
        end
    end

    // Every request answers with done one cycle later, allowed writes at their end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_q <= 1'b0;
            denied_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            denied_q <= 1'b0;
            if (state_q == S_WRITE && cnt_q == 16'h0000) begin
                done_q <= 1'b1;
            end
            if (idle_req) begin
                unique case (link.op)
                    flash_iap_pkg::OP_DATA_WR: begin
                        done_q <= !wr_ok;
                        denied_q <= !wr_ok;
                        rdata_q <= 8'h00;
                    end
                    flash_iap_pkg::OP_DATA_RD: begin
                        done_q <= 1'b1;
                        denied_q <= !wr_ok;
                        rdata_q <= wr_ok ? mem[link.addr] : 8'h00;
                    end
                    flash_iap_pkg::OP_CODE_RD: begin
                        done_q <= 1'b1;
                        denied_q <= !flash_iap_pkg::code_read_ok(link.addr, lock_q);
                        rdata_q <= flash_iap_pkg::code_read_ok(link.addr, lock_q)
                            ? mem[link.addr] : 8'h00;
                    end
                    flash_iap_pkg::OP_SFR_WR: begin
                        done_q <= 1'b1;
                    end
                    flash_iap_pkg::OP_SFR_RD: begin
                        done_q <= 1'b1;
                        if (link.addr[7:0] == flash_iap_pkg::CMD_REG_SFR) begin
                            rdata_q <= {7'h00, wide_q};
                        end else if (link.addr[7:0] == flash_iap_pkg::CFG_LOW_SFR) begin
                            rdata_q <= cfg_low_q;
                        end else if (link.addr[7:0] == flash_iap_pkg::SUPPLY_SFR) begin
                            rdata_q <= supply_q;
                        end else begin
                            rdata_q <= 8'h00;
                        end
                    end
                    default: begin
                        done_q <= 1'b1;
                        denied_q <= 1'b1;
                        rdata_q <= 8'h00;
                    end
                endcase
            end
        end
    end

    // Designated pin driven low for the whole six-wire session
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_o_q <= 1'b0;
            hold_oe_q <= 1'b0;
        end else begin
            hold_o_q <= 1'b0;
            hold_oe_q <= six_wire_session;
        end
    end

    assign link.done = done_q;
    assign link.denied = denied_q;
    assign link.rdata = rdata_q;
    assign link.busy = busy_q;
    assign link.core_supply_saving = supply_q[flash_iap_pkg::SUPPLY_SAVE_BIT];
    assign hold_pin_o = hold_o_q;
    assign hold_pin_oe = hold_oe_q;
    assign core_supply_saving = supply_q[flash_iap_pkg::SUPPLY_SAVE_BIT];
    assign cfg_low_sfr = cfg_low_q;
endmodule

/* flash_iap_pkg.sv */
// Shared constants, command codes and permission logic for in-application flash access
package flash_iap_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned WR_TIME_US = 500;
    localparam int unsigned WR_CYCLES = (WR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned ADDR_W = 14;
    localparam int unsigned FLASH_BYTES = 16384;
    localparam logic [13:0] LOCK_AREA_END = 14'h01FF;
    localparam logic [13:0] FREE_AREA_START = 14'h3F00;
    localparam logic [13:0] FREE_AREA_END = 14'h3FFD;
    localparam logic [13:0] CFG_LOW_ADDR = 14'h3FFE;
    localparam logic [13:0] CFG_HIGH_ADDR = 14'h3FFF;
    localparam int unsigned LOCK_BIT = 5;
    localparam int unsigned SUPPLY_SAVE_BIT = 6;

    localparam logic [7:0] CMD_REG_SFR = 8'h97;
    localparam logic [7:0] CFG_LOW_SFR = 8'hF7;
    localparam logic [7:0] SUPPLY_SFR = 8'hA7;
    localparam logic [7:0] WIDE_KEY = 8'h65;
    localparam logic [7:0] SUPPLY_RESET = 8'h22;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    localparam logic [7:0] HOST_CMD_OFF = 8'h00;
    localparam logic [7:0] HOST_ADDR_OFF = 8'h04;
    localparam logic [7:0] HOST_WDATA_OFF = 8'h08;
    localparam logic [7:0] HOST_STATUS_OFF = 8'h0C;
    localparam logic [7:0] HOST_RDATA_OFF = 8'h10;
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_DENIED = 1;
    localparam int unsigned ST_REFUSED = 2;
    localparam int unsigned ST_IRQ = 3;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_DATA_WR = 3'b001,
        OP_DATA_RD = 3'b010,
        OP_CODE_RD = 3'b011,
        OP_SFR_WR = 3'b100,
        OP_SFR_RD = 3'b101
    } op_t;

    function automatic logic data_move_ok(input logic [13:0] a, input logic lock,
                                          input logic wide);
        if (a <= LOCK_AREA_END) begin
            return !lock && wide;
        end else if (a < FREE_AREA_START) begin
            return wide;
        end else if (a <= FREE_AREA_END) begin
            return 1'b1;
        end else if (a == CFG_LOW_ADDR) begin
            return wide;
        end
        return 1'b0;
    endfunction

    function automatic logic code_read_ok(input logic [13:0] a, input logic lock);
        return !(lock && (a <= LOCK_AREA_END));
    endfunction
endpackage

/* flash_in_app_access_control_bench.sv */
// Self-checking bench joining the CPU-side port and the flash controller
`timescale 1ns/1ps
module flash_in_app_access_control_bench;
    localparam int unsigned WR_CYC = 8;
    localparam logic [31:0] A_CMD = {24'h00_0000, flash_iap_pkg::HOST_CMD_OFF};
    localparam logic [31:0] A_ADDR = {24'h00_0000, flash_iap_pkg::HOST_ADDR_OFF};
    localparam logic [31:0] A_WDAT = {24'h00_0000, flash_iap_pkg::HOST_WDATA_OFF};
    localparam logic [31:0] A_STAT = {24'h00_0000, flash_iap_pkg::HOST_STATUS_OFF};
    localparam logic [31:0] A_RDAT = {24'h00_0000, flash_iap_pkg::HOST_RDATA_OFF};
    localparam flash_iap_pkg::op_t DW = flash_iap_pkg::OP_DATA_WR;
    localparam flash_iap_pkg::op_t DR = flash_iap_pkg::OP_DATA_RD;
    localparam flash_iap_pkg::op_t CR = flash_iap_pkg::OP_CODE_RD;
    localparam flash_iap_pkg::op_t SW = flash_iap_pkg::OP_SFR_WR;
    localparam flash_iap_pkg::op_t SR = flash_iap_pkg::OP_SFR_RD;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic irq_req = 1'b0;
    logic irq_out;
    logic six_wire_session = 1'b0;
    logic hold_pin_o;
    logic hold_pin_oe;
    logic core_supply_saving;
    logic [7:0] cfg_low_sfr;
    logic rd_phase = 1'b0;
    logic prev_busy = 1'b0;
    logic [31:0] last;
    logic [63:0] mon_e;
    logic [63:0] exp_q[$];
    logic [13:0] base;
    logic [7:0] dat [2];
    logic [7:0] cfg;
    int bad_count = 0;
    int checks_done = 0;
    flash_link_if link();
    flash_iap_ctrl #(.WR_CYCLES(WR_CYC)) flash_iap_ctrl_i (.hclk(hclk), .hresetn(hresetn),
        .link(link), .six_wire_session(six_wire_session), .hold_pin_o(hold_pin_o),
        .hold_pin_oe(hold_pin_oe), .core_supply_saving(core_supply_saving),
        .cfg_low_sfr(cfg_low_sfr));
    flash_cpu_port flash_cpu_port_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .irq_req(irq_req), .irq_out(irq_out), .link(link));
    flash_link_props #(.WR_CYCLES(WR_CYC)) flash_link_props_i (.hclk(hclk),
        .hresetn(hresetn), .req(link.req), .op(link.op), .addr(link.addr),
        .wdata(link.wdata), .done(link.done), .denied(link.denied), .rdata(link.rdata),
        .busy(link.busy), .core_supply_saving(link.core_supply_saving));
    always #50 hclk = ~hclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Read results are compared when their data phase completes; mask 0 means poll only
    always @(posedge hclk) begin
        if (rd_phase && hready === 1'b1 && exp_q.size() > 0) begin
            mon_e = exp_q.pop_front();
            if (mon_e[63:32] !== 32'h0000_0000) begin
                check(hrdata & mon_e[63:32], mon_e[31:0]);
            end
        end
        rd_phase <= hsel && htrans[1] && !hwrite && hready;
    end
    // Pending interrupts must stay hidden through a write stall
    always @(negedge hclk) begin
        if (irq_req === 1'b1 && link.busy === 1'b1 && prev_busy === 1'b1) begin
            check(32'(irq_out), 32'h0000_0000);
        end
        prev_busy <= link.busy;
    end
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic [31:0] e);
        if (!w) begin
            exp_q.push_back({m, e & m});
        end
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        last = hrdata;
    endtask
    task automatic op(input flash_iap_pkg::op_t c, input logic [13:0] a, input logic [7:0] d);
        int n;
        bus(1'b1, A_ADDR, {18'h0_0000, a}, 32'h0000_0000, 32'h0000_0000);
        bus(1'b1, A_WDAT, {24'h00_0000, d}, 32'h0000_0000, 32'h0000_0000);
        bus(1'b1, A_CMD, {29'h0000_0000, c}, 32'h0000_0000, 32'h0000_0000);
        n = 0;
        do begin
            bus(1'b0, A_STAT, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
            n++;
        end while (last[0] !== 1'b0 && n < 100);
        // A poll that never sees idle counts as a mismatch
        if (last[0] !== 1'b0) begin
            bad_count++;
        end
    endtask
    task automatic access(input flash_iap_pkg::op_t c, input logic [13:0] a,
                          input logic [7:0] d, input logic den, input logic [7:0] e);
        op(c, a, d);
        bus(1'b0, A_STAT, 32'h0000_0000, 32'h0000_0002, {30'h0000_0000, den, 1'b0});
        bus(1'b1, A_STAT, 32'h0000_000E, 32'h0000_0000, 32'h0000_0000);
        if (c inside {DR, CR, SR}) begin
            bus(1'b0, A_RDAT, 32'h0000_0000, 32'h0000_00FF, {24'h00_0000, e});
        end
    endtask
    initial begin
        void'($urandom(64));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        check(32'(core_supply_saving), 32'h0000_0000);
        check(32'(cfg_low_sfr), 32'h0000_00FF);
        access(SR, 14'h0097, 8'h00, 1'b0, 8'h00);
        access(SR, 14'h00A7, 8'h00, 1'b0, 8'h22);
        bus(1'b0, 32'h0000_0014, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000);
        base = 14'h3F00 + 14'($urandom_range(0, 252));
        for (int i = 0; i < 2; i++) begin
            dat[i] = 8'($urandom);
            access(DW, base + 14'(i), dat[i], 1'b0, 8'h00);
        end
        for (int i = 0; i < 2; i++) begin
            access(DR, base + 14'(i), 8'h00, 1'b0, dat[i]);
        end
        access(CR, base, 8'h00, 1'b0, dat[0]);
        irq_req <= 1'b1;
        op(DW, 14'h3FFD, 8'h5A);
        bus(1'b0, A_STAT, 32'h0000_0000, 32'h0000_0008, 32'h0000_0008);
        check(32'(irq_out), 32'h0000_0001);
        irq_req <= 1'b0;
        access(DR, 14'h0200, 8'h00, 1'b1, 8'h00);
        check(32'(irq_out), 32'h0000_0000);
        check(32'(hresp), 32'h0000_0000);
        access(DW, 14'h3EFF, 8'h12, 1'b1, 8'h00);
        access(DR, 14'h3FFE, 8'h00, 1'b1, 8'h00);
        access(DR, 14'h0000, 8'h00, 1'b1, 8'h00);
        access(CR, 14'h01FF, 8'h00, 1'b1, 8'h00);
        access(CR, 14'h3FFF, 8'h00, 1'b0, 8'hFF);
        access(CR, 14'h0200, 8'h00, 1'b0, 8'hFF);
        access(SW, 14'h0097, 8'h65, 1'b0, 8'h00);
        access(SR, 14'h0097, 8'h00, 1'b0, 8'h01);
        access(DR, 14'h01FF, 8'h00, 1'b1, 8'h00);
        access(DW, 14'h0000, 8'h00, 1'b1, 8'h00);
        access(DW, 14'h3FFF, 8'h00, 1'b1, 8'h00);
        access(DW, 14'h2000, dat[1], 1'b0, 8'h00);
        access(DR, 14'h2000, 8'h00, 1'b0, dat[1]);
        access(DR, 14'h3EFF, 8'h00, 1'b0, 8'hFF);
        cfg = 8'($urandom);
        access(DW, 14'h3FFE, cfg, 1'b0, 8'h00);
        access(SW, 14'h0097, 8'h65 ^ 8'($urandom_range(1, 255)), 1'b0, 8'h00);
        access(SR, 14'h0097, 8'h00, 1'b0, 8'h00);
        access(SW, 14'h00A7, 8'h62, 1'b0, 8'h00);
        check(32'(core_supply_saving), 32'h0000_0001);
        op(DW, base, 8'h00);
        bus(1'b0, A_STAT, 32'h0000_0000, 32'h0000_0004, 32'h0000_0004);
        bus(1'b1, A_STAT, 32'h0000_0004, 32'h0000_0000, 32'h0000_0000);
        access(DR, base, 8'h00, 1'b0, dat[0]);
        access(SW, 14'h00A7, 8'h22, 1'b0, 8'h00);
        access(SW, 14'h00F7, dat[1], 1'b0, 8'h00);
        check(32'(cfg_low_sfr), 32'(dat[1]));
        six_wire_session <= 1'b1;
        repeat (2) @(posedge hclk);
        check({30'h0000_0000, hold_pin_oe, hold_pin_o}, 32'h0000_0002);
        six_wire_session <= 1'b0;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        check(32'(cfg_low_sfr), 32'(cfg));
        check(32'(hold_pin_oe), 32'h0000_0000);
        access(SR, 14'h0097, 8'h00, 1'b0, 8'h00);
        access(DR, 14'h2000, 8'h00, 1'b1, 8'h00);
        access(DR, base + 14'h0001, 8'h00, 1'b0, dat[1]);
        summarize();
    end
    initial begin
        #3ms;
        bad_count++;
        summarize();
    end
endmodule

/* flash_link_if.sv */
// Link between the CPU-side access controller and the flash controller
`timescale 1ns/1ps
interface flash_link_if;
    logic req;
    flash_iap_pkg::op_t op;
    logic [13:0] addr;
    logic [7:0] wdata;
    logic done;
    logic denied;
    logic [7:0] rdata;
    logic busy;
    logic core_supply_saving;

    modport device (input req, op, addr, wdata,
                    output done, denied, rdata, busy, core_supply_saving);
    modport cpu (output req, op, addr, wdata,
                 input done, denied, rdata, busy, core_supply_saving);
endinterface

/* flash_link_props.sv */
// Link protocol and permission assertions between the CPU-side port and flash controller
`timescale 1ns/1ps
module flash_link_props #(
    parameter int unsigned WR_CYCLES = flash_iap_pkg::WR_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req,
    input wire flash_iap_pkg::op_t op,
    input wire logic [13:0] addr,
    input wire logic [7:0] wdata,
    input wire logic done,
    input wire logic denied,
    input wire logic [7:0] rdata,
    input wire logic busy,
    input wire logic core_supply_saving
);
    logic take;
    logic cmd_hit;
    logic mid;
    logic wide_q;
    logic wr_q;
    logic [15:0] cnt_q;
    assign take = req && !busy;
    assign cmd_hit = take && op == flash_iap_pkg::OP_SFR_WR
        && addr[7:0] == flash_iap_pkg::CMD_REG_SFR;
    assign mid = addr > flash_iap_pkg::LOCK_AREA_END && addr < flash_iap_pkg::FREE_AREA_START;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Flash powers up erased, so the lock stays set; only the wide flag is mirrored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wide_q <= 1'b0;
        end else if (cmd_hit) begin
            wide_q <= (wdata == flash_iap_pkg::WIDE_KEY);
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
        end else if (done) begin
            wr_q <= 1'b0;
        end else if (take && op == flash_iap_pkg::OP_DATA_WR) begin
            wr_q <= 1'b1;
        end
    end
    // Length of the current busy stretch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= busy ? cnt_q + 16'h0001 : 16'h0000;
        end
    end
    done_single_a: assert property (done |=> !done)
        else $error("done held longer than one cycle");
    denied_done_a: assert property (denied |-> done && rdata == 8'h00)
        else $error("denied without done or with data");
    read_prompt_a: assert property (take && op inside {flash_iap_pkg::OP_DATA_RD,
        flash_iap_pkg::OP_CODE_RD} |=> done && !busy) else $error("read not answered at once");
    free_write_a: assert property (take && op == flash_iap_pkg::OP_DATA_WR
        && addr >= flash_iap_pkg::FREE_AREA_START && addr <= flash_iap_pkg::FREE_AREA_END
        |=> busy && !done) else $error("free area write did not stall");
    write_time_a: assert property ($fell(busy) && wr_q |-> done && !denied
        && cnt_q == 16'(WR_CYCLES)) else $error("write stall length wrong");
    top_byte_a: assert property (take && op inside {flash_iap_pkg::OP_DATA_WR,
        flash_iap_pkg::OP_DATA_RD} && addr == flash_iap_pkg::CFG_HIGH_ADDR
        |=> done && denied && !busy) else $error("top config byte reached by data move");
    lock_area_a: assert property (take && op inside {flash_iap_pkg::OP_DATA_WR,
        flash_iap_pkg::OP_DATA_RD, flash_iap_pkg::OP_CODE_RD}
        && addr <= flash_iap_pkg::LOCK_AREA_END |=> done && denied)
        else $error("locked area reachable");
    main_wide_a: assert property (take && op == flash_iap_pkg::OP_DATA_RD && mid
        |=> done && denied == !wide_q) else $error("main area ignores wide flag");
    flag_read_a: assert property (take && op == flash_iap_pkg::OP_SFR_RD
        && addr[7:0] == flash_iap_pkg::CMD_REG_SFR |=> done && rdata == {7'h00, wide_q})
        else $error("command register read wrong");
    code_main_a: assert property (take && op == flash_iap_pkg::OP_CODE_RD
        && addr > flash_iap_pkg::LOCK_AREA_END |=> done && !denied)
        else $error("code read denied outside locked area");
endmodule
